// ### logic/edu_cfg.svh
// Constants for the exception dispatch unit
`ifndef EDU_CFG_SVH
`define EDU_CFG_SVH

// ==================================================
// Exception vectors
`define EDU_VEC_BP 8'h03
`define EDU_VEC_OF 8'h04
`define EDU_VEC_BR 8'h05
`define EDU_VEC_MF 8'h10
`define EDU_VEC_XF 8'h13

// ==================================================
// Push and pop widths in bytes
`define EDU_WID_REAL 4'h2
`define EDU_WID_LEG 4'h4
`define EDU_WID_64 4'h8
`define EDU_TASK_STRIDE 4'h8

// ==================================================
// Word counts of the stored frames
`define EDU_TASK_WORDS 3'h5
`define EDU_INTERRUPT_RETURN_INSTRUCTION_WORDS_LEG 3'h3
`define EDU_INTERRUPT_RETURN_INSTRUCTION_WORDS_64 3'h5

// ==================================================
// Real-mode table entry layout: offset low, segment high
`define EDU_IVT_SHIFT 2
`define EDU_IVT_IP_MSB 15
`define EDU_IVT_CS_LSB 16
`define EDU_IVT_CS_MSB 31

// ==================================================
// Floating-point condition count
`define EDU_FP_CONDS 6

`endif

// ### logic/edu_pkg.sv
// Types for the exception dispatch unit
package edu_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        S_IDLE,
        S_TABLE,
        S_PUSH,
        S_DONE,
        S_RESTORE,
        S_RESUME
    } state_type;

endpackage

// ### logic/fp_exc_router.sv
// Routes floating-point conditions to the legacy or SIMD exception vector
`timescale 1ns/1ps
`default_nettype none
`include "edu_cfg.svh"

module fp_exc_router #(
    parameter int NCOND = `EDU_FP_CONDS
) (
    // Condition sources
    input wire logic legacy_op,
    input wire logic simd_op,
    input wire logic [NCOND-1:0] cond,
    // Routed exception
    output logic valid,
    output logic [7:0] vector
);

    // Any condition of the six raises exactly one exception when legacy_op or simd_op is set
    always_comb
    begin
        valid = 1'b0;
        vector = `EDU_VEC_MF;
        if (simd_op && (|cond))
        begin
            valid = 1'b1;
            vector = `EDU_VEC_XF;
        end
        else if (legacy_op && (|cond))
        begin
            valid = 1'b1;
            vector = `EDU_VEC_MF;
        end
    end

endmodule
`default_nettype wire

// ### logic/bound_checker.sv
// Signed range check of an operand against lower and upper limits
`timescale 1ns/1ps
`default_nettype none

module bound_checker #(
    parameter int W = 32
) (
    // Operand and limits
    input wire logic [W-1:0] operand,
    input wire logic [W-1:0] lower,
    input wire logic [W-1:0] upper,
    // Result
    output logic outside
);

    // Limits are inclusive, so equal values pass
    always_comb
    begin
        outside = ($signed(operand) < $signed(lower)) || ($signed(operand) > $signed(upper));
    end

endmodule
`default_nettype wire

// ### logic/exception_dispatch_unit.sv
// Exception and interrupt dispatch sequencer
`timescale 1ns/1ps
`default_nettype none
`include "edu_cfg.svh"

// Functional notes
// - Task gate delivery saves full interrupted state
// - Task return restores saved state, resumes
// - Real mode indexes table by vector
// - Real mode pushes flags, selector, pointer, error
// - Interrupt return pops and restores entry values
// - Software interrupt reaches any vector
// - Overflow trap only when overflow flag set
// - Arithmetic overflow sets flag, never traps
// - Software vector four reaches overflow handler
// - Breakpoint instruction calls breakpoint handler
// - Bounds check traps when operand outside
// - Software vector five reaches range handler
// - No implicit bounds checks anywhere
// - Six floating-point conditions are detected
// - Legacy float conditions raise float error
// - Packed SIMD conditions raise SIMD exception
// - Long mode handlers run 64-bit, except management
// - Long mode pushes are zero-extended 8 bytes
// - Long mode always pushes stack selector, pointer
// - Long mode privilege change nulls stack selector
module exception_dispatch_unit
    import edu_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Operating mode
    input wire logic real_mode,
    input wire logic long_mode,
    input wire logic [1:0] current_privilege_level,
    input wire logic [1:0] handler_cpl,
    // Interrupted context
    input wire logic [63:0] flags_register,
    input wire logic [63:0] instruction_pointer,
    input wire logic [15:0] cs_in,
    input wire logic [63:0] stack_pointer,
    input wire logic [15:0] ss_in,
    // Overflow flag upkeep
    input wire logic arith_overflow,
    input wire logic of_clear,
    // Explicit and external requests
    input wire logic swi_req,
    input wire logic [7:0] swi_vector,
    input wire logic into_req,
    input wire logic brk_req,
    input wire logic bound_req,
    input wire logic [31:0] bound_operand,
    input wire logic [31:0] bound_lower,
    input wire logic [31:0] bound_upper,
    input wire logic fp_legacy_req,
    input wire logic fp_simd_req,
    input wire logic [`EDU_FP_CONDS-1:0] fp_cond,
    input wire logic ext_req,
    input wire logic [7:0] ext_vector,
    input wire logic system_management_interrupt,
    input wire logic err_valid,
    input wire logic [31:0] err_code,
    // Gate and table information
    input wire logic task_gate,
    input wire logic [15:0] gate_cs,
    input wire logic [63:0] gate_ip,
    input wire logic [63:0] table_base,
    input wire logic [63:0] save_base,
    // Returns
    input wire logic interrupt_return_instruction_req,
    input wire logic task_ret_req,
    // Memory port
    output logic mem_req,
    output logic mem_we,
    output logic [63:0] mem_addr,
    output logic [63:0] mem_wdata,
    input wire logic [63:0] mem_rdata,
    input wire logic mem_ack,
    // Delivery results
    output logic busy,
    output logic deliver,
    output logic [7:0] deliver_vector,
    output logic [15:0] new_cs,
    output logic [63:0] new_ip,
    output logic [63:0] new_sp,
    output logic [15:0] new_ss,
    output logic ss_null_load,
    output logic code64,
    output logic task_switch,
    output logic overflow_flag,
    // Return results
    output logic resume,
    output logic [63:0] res_ip,
    output logic [15:0] res_cs,
    output logic [63:0] res_flags,
    output logic [63:0] res_sp,
    output logic [15:0] res_ss
);

    // ==================================================
    // Request decode
    logic fp_valid;
    logic [7:0] fp_vec;
    logic bound_out;

    fp_exc_router #(.NCOND(`EDU_FP_CONDS)) u_fp (
        .legacy_op(fp_legacy_req),
        .simd_op(fp_simd_req),
        .cond(fp_cond),
        .valid(fp_valid),
        .vector(fp_vec)
    );

    bound_checker #(.W(32)) u_bound (
        .operand(bound_operand),
        .lower(bound_lower),
        .upper(bound_upper),
        .outside(bound_out)
    );

    // Candidate events; an overflow trap with a clear flag and an in-range check fall away
    logic into_hit;
    logic bound_hit;
    logic any_evt;
    logic [7:0] evt_vec;
    assign into_hit = into_req && overflow_flag;
    assign bound_hit = bound_req && bound_out;
    assign any_evt = fp_valid || bound_hit || into_hit || brk_req || swi_req || ext_req;

    // Fixed priority among same-cycle sources
    always_comb
    begin
        if (fp_valid)
            evt_vec = fp_vec;
        else if (bound_hit)
            evt_vec = `EDU_VEC_BR;
        else if (into_hit)
            evt_vec = `EDU_VEC_OF;
        else if (brk_req)
            evt_vec = `EDU_VEC_BP;
        else if (swi_req)
            evt_vec = swi_vector;
        else
            evt_vec = ext_vector;
    end

    // ==================================================
    // Overflow flag: arithmetic only sets it, set wins over clear
    logic of_d;
    logic of_q;
    always_comb
    begin
        of_d = of_q;
        if (of_clear)
            of_d = 1'b0;
        if (arith_overflow)
            of_d = 1'b1;
    end
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            of_q <= 1'b0;
        else
            of_q <= of_d;
    end
    assign overflow_flag = of_q;

    // ==================================================
    // Sequencer
    state_type st_q, st_d;
    logic [7:0] vec_q, vec_d;
    logic [2:0] n_q, n_d, idx_q, idx_d;
    logic [3:0] wid_q, wid_d;
    logic [63:0] base_q, base_d, nsp_q, nsp_d, hip_q, hip_d;
    logic [15:0] hcs_q, hcs_d, nss_q, nss_d;
    logic task_q, task_d, c64_q, c64_d, null_q, null_d;
    logic dlv_q, dlv_d, rsm_q, rsm_d, tsw_q, tsw_d;
    logic [63:0] w_q [0:5];
    logic [63:0] w_d [0:5];
    logic [2:0] k;
    logic [3:0] wsel;
    logic push_ss;

    // Byte offset of the current word from its base
    logic [63:0] step;
    assign step = 64'(idx_q) * 64'(wid_q);

    always_comb
    begin
        st_d = st_q;
        vec_d = vec_q;
        n_d = n_q;
        idx_d = idx_q;
        wid_d = wid_q;
        base_d = base_q;
        nsp_d = nsp_q;
        hip_d = hip_q;
        hcs_d = hcs_q;
        nss_d = nss_q;
        task_d = task_q;
        c64_d = c64_q;
        null_d = 1'b0;
        dlv_d = 1'b0;
        rsm_d = 1'b0;
        tsw_d = 1'b0;
        w_d = w_q;
        k = 3'h0;
        wsel = real_mode ? `EDU_WID_REAL : (long_mode ? `EDU_WID_64 : `EDU_WID_LEG);
        push_ss = long_mode || (current_privilege_level != handler_cpl);
        case (st_q)
            S_IDLE:
            begin
                idx_d = 3'h0;
                if (task_ret_req)
                begin
                    // Reload the saved frame from the save area
                    st_d = S_RESTORE;
                    task_d = 1'b1;
                    n_d = `EDU_TASK_WORDS;
                    wid_d = `EDU_TASK_STRIDE;
                    base_d = save_base;
                end
                else if (interrupt_return_instruction_req)
                begin
                    // Pop pointer, selector, flags; stack words too in long mode
                    st_d = S_RESTORE;
                    task_d = 1'b0;
                    wid_d = wsel;
                    base_d = stack_pointer;
                    n_d = long_mode ? `EDU_INTERRUPT_RETURN_INSTRUCTION_WORDS_64 : `EDU_INTERRUPT_RETURN_INSTRUCTION_WORDS_LEG;
                    w_d[3] = stack_pointer + 64'(`EDU_INTERRUPT_RETURN_INSTRUCTION_WORDS_LEG) * 64'(wsel);
                    w_d[4] = {48'h0, ss_in};
                end
                else if (any_evt)
                begin
                    vec_d = evt_vec;
                    hcs_d = gate_cs;
                    hip_d = gate_ip;
                    nss_d = ss_in;
                    c64_d = long_mode && !system_management_interrupt;
                    if (task_gate && !real_mode)
                    begin
                        // Whole interrupted context goes to the save area
                        task_d = 1'b1;
                        wid_d = `EDU_TASK_STRIDE;
                        base_d = save_base;
                        n_d = `EDU_TASK_WORDS;
                        nsp_d = stack_pointer;
                        w_d[0] = instruction_pointer;
                        w_d[1] = {48'h0, cs_in};
                        w_d[2] = flags_register;
                        w_d[3] = stack_pointer;
                        w_d[4] = {48'h0, ss_in};
                        st_d = S_PUSH;
                    end
                    else
                    begin
                        // Build the stack frame, outermost word first
                        task_d = 1'b0;
                        wid_d = wsel;
                        base_d = stack_pointer;
                        if (push_ss && !real_mode)
                        begin
                            w_d[0] = {48'h0, ss_in};
                            w_d[1] = stack_pointer;
                            k = 3'h2;
                        end
                        w_d[k] = flags_register;
                        w_d[k + 3'h1] = {48'h0, cs_in};
                        w_d[k + 3'h2] = instruction_pointer;
                        k = k + 3'h3;
                        if (err_valid)
                        begin
                            w_d[k] = {32'h0, err_code};
                            k = k + 3'h1;
                        end
                        n_d = k;
                        nsp_d = stack_pointer - 64'(k) * 64'(wsel);
                        if (long_mode && (current_privilege_level != handler_cpl))
                            nss_d = 16'h0;
                        st_d = real_mode ? S_TABLE : S_PUSH;
                    end
                end
            end
            S_TABLE:
            begin
                if (mem_ack)
                begin
                    hip_d = {48'h0, mem_rdata[`EDU_IVT_IP_MSB:0]};
                    hcs_d = mem_rdata[`EDU_IVT_CS_MSB:`EDU_IVT_CS_LSB];
                    st_d = S_PUSH;
                end
            end
            S_PUSH:
            begin
                if (mem_ack)
                begin
                    idx_d = idx_q + 3'h1;
                    if (idx_q == n_q - 3'h1)
                        st_d = S_DONE;
                end
            end
            S_DONE:
            begin
                dlv_d = 1'b1;
                tsw_d = task_q;
                null_d = c64_q && !task_q && (nss_q == 16'h0) && (ss_in != 16'h0);
                st_d = S_IDLE;
            end
            S_RESTORE:
            begin
                if (mem_ack)
                begin
                    w_d[idx_q] = mem_rdata;
                    idx_d = idx_q + 3'h1;
                    if (idx_q == n_q - 3'h1)
                        st_d = S_RESUME;
                end
            end
            S_RESUME:
            begin
                rsm_d = 1'b1;
                st_d = S_IDLE;
            end
            default:
                st_d = S_IDLE;
        endcase
    end

    // Register every sequencer field
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q <= S_IDLE;
            vec_q <= 8'h00;
            n_q <= 3'h0;
            idx_q <= 3'h0;
            wid_q <= 4'h0;
            base_q <= 64'h0;
            nsp_q <= 64'h0;
            hip_q <= 64'h0;
            hcs_q <= 16'h0;
            nss_q <= 16'h0;
            task_q <= 1'b0;
            c64_q <= 1'b0;
            null_q <= 1'b0;
            dlv_q <= 1'b0;
            rsm_q <= 1'b0;
            tsw_q <= 1'b0;
            for (int i = 0; i < 6; i++)
                w_q[i] <= 64'h0;
        end
        else
        begin
            st_q <= st_d;
            vec_q <= vec_d;
            n_q <= n_d;
            idx_q <= idx_d;
            wid_q <= wid_d;
            base_q <= base_d;
            nsp_q <= nsp_d;
            hip_q <= hip_d;
            hcs_q <= hcs_d;
            nss_q <= nss_d;
            task_q <= task_d;
            c64_q <= c64_d;
            null_q <= null_d;
            dlv_q <= dlv_d;
            rsm_q <= rsm_d;
            tsw_q <= tsw_d;
            for (int i = 0; i < 6; i++)
                w_q[i] <= w_d[i];
        end
    end

    // ==================================================
    // Memory port: stack grows down, save area and pops grow up
    logic [63:0] wmask;
    assign wmask = (wid_q == `EDU_WID_REAL) ? 64'h000000000000ffff :
                   (wid_q == `EDU_WID_LEG) ? 64'h00000000ffffffff : 64'hffffffffffffffff;
    assign mem_req = (st_q == S_TABLE) || (st_q == S_PUSH) || (st_q == S_RESTORE);
    assign mem_we = (st_q == S_PUSH);
    assign mem_wdata = (st_q == S_PUSH) ? (w_q[idx_q] & wmask) : 64'h0;
    always_comb
    begin
        if (st_q == S_TABLE)
            mem_addr = table_base + ({56'h0, vec_q} << `EDU_IVT_SHIFT);
        else if (st_q == S_PUSH && !task_q)
            mem_addr = base_q - step - 64'(wid_q);
        else if (mem_req)
            mem_addr = base_q + step;
        else
            mem_addr = 64'h0;
    end

    // Outputs straight from flops
    assign busy = (st_q != S_IDLE);
    assign deliver = dlv_q;
    assign deliver_vector = vec_q;
    assign new_cs = hcs_q;
    assign new_ip = hip_q;
    assign new_sp = nsp_q;
    assign new_ss = nss_q;
    assign ss_null_load = null_q;
    assign code64 = c64_q;
    assign task_switch = tsw_q;
    assign resume = rsm_q;
    assign res_ip = w_q[0];
    assign res_cs = w_q[1][15:0];
    assign res_flags = w_q[2];
    assign res_sp = w_q[3];
    assign res_ss = w_q[4][15:0];

    // ==================================================
    // Checks
    logic idle_only;
    assign idle_only = (st_q == S_IDLE) && !interrupt_return_instruction_req && !task_ret_req;

    property p_into_clear;
        @(posedge ref_clk) disable iff (!arst_n)
        idle_only && into_req && !overflow_flag && !swi_req && !brk_req && !ext_req && !fp_valid && !bound_req
        |=> (st_q == S_IDLE);
    endproperty
    a_into_clear: assert property (p_into_clear) else $error("overflow trap ran with flag clear");

    property p_of_sticky;
        @(posedge ref_clk) disable iff (!arst_n)
        arith_overflow |=> overflow_flag && (st_q == S_IDLE || $past(any_evt) || $past(st_q != S_IDLE));
    endproperty
    a_of_sticky: assert property (p_of_sticky) else $error("overflow did not set flag or raised trap");

    property p_brk;
        @(posedge ref_clk) disable iff (!arst_n)
        idle_only && brk_req && !fp_valid && !bound_hit && !into_hit |=> (vec_q == `EDU_VEC_BP) ##1 busy;
    endproperty
    a_brk: assert property (p_brk) else $error("breakpoint vector wrong");

    property p_swi;
        @(posedge ref_clk) disable iff (!arst_n)
        idle_only && swi_req && !fp_valid && !bound_hit && !into_hit && !brk_req |=> (vec_q == $past(swi_vector));
    endproperty
    a_swi: assert property (p_swi) else $error("software vector not taken");

    property p_bound_in;
        @(posedge ref_clk) disable iff (!arst_n)
        idle_only && bound_req && !bound_out && !any_evt |=> (st_q == S_IDLE);
    endproperty
    a_bound_in: assert property (p_bound_in) else $error("in-range check raised exception");

    property p_simd;
        @(posedge ref_clk) disable iff (!arst_n)
        idle_only && fp_simd_req && (|fp_cond) |=> (vec_q == `EDU_VEC_XF);
    endproperty
    a_simd: assert property (p_simd) else $error("SIMD condition not routed");

    property p_legacy;
        @(posedge ref_clk) disable iff (!arst_n)
        idle_only && fp_legacy_req && !fp_simd_req && (|fp_cond) |=> (vec_q == `EDU_VEC_MF);
    endproperty
    a_legacy: assert property (p_legacy) else $error("legacy float condition not routed");

    property p_wide;
        @(posedge ref_clk) disable iff (!arst_n)
        (st_q == S_PUSH) && !task_q && c64_q |-> (wid_q == `EDU_WID_64) && (n_q >= 3'h5);
    endproperty
    a_wide: assert property (p_wide) else $error("long mode frame too narrow");

    property p_c64;
        @(posedge ref_clk) disable iff (!arst_n)
        idle_only && any_evt && long_mode && !system_management_interrupt |=> code64 ##[1:1000] deliver;
    endproperty
    a_c64: assert property (p_c64) else $error("handler not 64-bit");

    property p_real_tbl;
        @(posedge ref_clk) disable iff (!arst_n)
        (st_q == S_TABLE) |-> !mem_we && (mem_addr[1:0] == 2'h0) && (mem_addr - table_base == {54'h0, vec_q, 2'h0});
    endproperty
    a_real_tbl: assert property (p_real_tbl) else $error("table address wrong");

    property p_task;
        @(posedge ref_clk) disable iff (!arst_n)
        task_switch |-> deliver && $past(task_q) && (n_q == `EDU_TASK_WORDS);
    endproperty
    a_task: assert property (p_task) else $error("task switch without full save");

    c_real: cover property (@(posedge ref_clk) disable iff (!arst_n) (st_q == S_TABLE) ##[1:20] deliver);
    c_task_ret: cover property (@(posedge ref_clk) disable iff (!arst_n) resume && task_q);
    c_null: cover property (@(posedge ref_clk) disable iff (!arst_n) ss_null_load);

endmodule
`default_nettype wire

// ### verification/exception_dispatch_unit_test.sv
// Self-checking bench for the exception dispatch unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fail_count++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end

module exception_dispatch_unit_test;
    import edu_pkg::*;
    // ==================================================
    // Stimulus and observation signals
    logic ref_clk = 0, arst_n = 0, real_mode = 1, long_mode = 0, arith_overflow = 0, of_clear = 0;
    logic [1:0] current_privilege_level = 0, handler_cpl = 0;
    logic [63:0] flags_register = 64'h246, instruction_pointer = 64'habc, stack_pointer = 64'h1000;
    logic [63:0] table_base = 0, save_base = 64'h200, gate_ip = 64'h40, mem_rdata = 0;
    logic [15:0] cs_in = 16'h1234, ss_in = 0, gate_cs = 16'h8;
    logic swi_req = 0, into_req = 0, brk_req = 0, bound_req = 0, fp_legacy_req = 0, fp_simd_req = 0;
    logic ext_req = 0, system_management_interrupt = 0, err_valid = 0, task_gate = 0, interrupt_return_instruction_req = 0;
    logic task_ret_req = 0, mem_ack = 0;
    logic [7:0] swi_vector = 0, ext_vector = 0;
    logic [31:0] bound_operand = 0, bound_lower = 0, bound_upper = 32'ha, err_code = 0;
    logic [5:0] fp_cond = 0;
    logic mem_req, mem_we, busy, deliver, ss_null_load, code64, task_switch, overflow_flag, resume;
    logic [63:0] mem_addr, mem_wdata, new_ip, new_sp, res_ip, res_flags, res_sp;
    logic [7:0] deliver_vector;
    logic [15:0] new_cs, new_ss, res_cs, res_ss;
    logic [63:0] wa[$], wd[$];
    int fail_count = 0, cmp_count = 0, cyc = 0;
    bit hit;

    exception_dispatch_unit DUT (.ref_clk, .arst_n, .real_mode, .long_mode, .current_privilege_level,
        .handler_cpl, .flags_register, .instruction_pointer, .cs_in, .stack_pointer, .ss_in, .arith_overflow,
        .of_clear, .swi_req, .swi_vector, .into_req, .brk_req, .bound_req, .bound_operand, .bound_lower,
        .bound_upper, .fp_legacy_req, .fp_simd_req, .fp_cond, .ext_req, .ext_vector,
        .system_management_interrupt, .err_valid, .err_code, .task_gate, .gate_cs, .gate_ip, .table_base,
        .save_base, .interrupt_return_instruction_req, .task_ret_req, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
        .busy, .deliver, .deliver_vector, .new_cs, .new_ip, .new_sp, .new_ss, .ss_null_load, .code64,
        .task_switch, .overflow_flag, .resume, .res_ip, .res_cs, .res_flags, .res_sp, .res_ss);

    // ==================================================
    // Clock, memory answer and write log
    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end

    // Read data is the inverted address so every word differs from its neighbours
    always @(negedge ref_clk)
    begin
        mem_ack <= mem_req;
        mem_rdata <= ~mem_addr;
    end

    always @(posedge ref_clk)
    begin
        if (mem_req === 1'b1 && mem_ack === 1'b1 && mem_we === 1'b1)
        begin
            wa.push_back(mem_addr);
            wd.push_back(mem_wdata);
        end
        cyc++;
        if (cyc > 3000)
        begin
            fail_count++;
            end_sim();
        end
    end

    // ==================================================
    // One-cycle request, then bounded wait for deliver or resume
    task automatic fire(input int k, output bit h);
        wa.delete();
        wd.delete();
        @(negedge ref_clk);
        {brk_req, into_req, swi_req, bound_req, fp_legacy_req, fp_simd_req, interrupt_return_instruction_req, task_ret_req} = 8'h80 >> k;
        @(negedge ref_clk);
        {brk_req, into_req, swi_req, bound_req, fp_legacy_req, fp_simd_req, interrupt_return_instruction_req, task_ret_req} = '0;
        h = 0;
        repeat (30)
        begin
            @(negedge ref_clk);
            if (deliver === 1'b1 || resume === 1'b1)
            begin
                h = 1;
                break;
            end
        end
    endtask

    // Real mode breakpoint entry and interrupt return
    task automatic t_real();
        fire(0, hit);
        `CHK("bp_vec", 8'h03, deliver_vector)
        `CHK("bp_ip", 16'hfff3, new_ip[15:0])
        `CHK("bp_cs", 16'hffff, new_cs)
        `CHK("bp_nw", 3, wa.size())
        `CHK("bp_a0", 64'h0ffe, wa[0])
        `CHK("bp_a2", 64'h0ffa, wa[2])
        `CHK("bp_fl", 16'h0246, wd[0][15:0])
        `CHK("bp_cs_push", 16'h1234, wd[1][15:0])
        `CHK("bp_ip_push", 16'h0abc, wd[2][15:0])
        stack_pointer = 64'h0ffa;
        fire(6, hit);
        `CHK("ir_hit", 1'b1, resume)
        `CHK("ir_ip", 16'hf005, res_ip[15:0])
        `CHK("ir_cs", 16'hf003, res_cs)
        `CHK("ir_fl", 16'hf001, res_flags[15:0])
        `CHK("ir_sp", 16'h1000, res_sp[15:0])
    endtask

    // Overflow flag and the overflow trap, legacy mode
    task automatic t_ovf();
        real_mode = 0;
        fire(1, hit);
        `CHK("into_clear", 1'b0, hit)
        arith_overflow = 1;
        @(negedge ref_clk);
        arith_overflow = 0;
        repeat (8) @(negedge ref_clk);
        `CHK("of_set", 1'b1, overflow_flag)
        `CHK("of_notrap", 1'b0, busy)
        err_valid = 1;
        err_code = 32'h1e;
        fire(1, hit);
        `CHK("into_vec", 8'h04, deliver_vector)
        `CHK("of_nw", 4, wa.size())
        `CHK("of_err", 64'h1e, wd[3])
        err_valid = 0;
        swi_vector = 8'h04;
        fire(2, hit);
        `CHK("swi4_hit", 1'b1, hit)
        `CHK("swi4_vec", 8'h04, deliver_vector)
        of_clear = 1;
        @(negedge ref_clk);
        of_clear = 0;
        @(negedge ref_clk);
        `CHK("of_clr", 1'b0, overflow_flag)
    endtask

    // Software vectors and signed inclusive range check
    task automatic t_swi_bound();
        logic [7:0] v[3] = '{8'h05, 8'h40, 8'hff};
        logic [31:0] op[3] = '{32'ha, 32'hb, 32'hffffffff};
        foreach (v[i])
        begin
            swi_vector = v[i];
            fire(2, hit);
            `CHK("swi_vec", v[i], deliver_vector)
        end
        foreach (op[i])
        begin
            bound_operand = op[i];
            fire(3, hit);
            `CHK("bnd_hit", i != 0, hit)
        end
        `CHK("bnd_vec", 8'h05, deliver_vector)
    endtask

    // Each condition routed to the legacy and the SIMD vector
    task automatic t_fp();
        fire(4, hit);
        `CHK("fp_none", 1'b0, hit)
        for (int i = 0; i < 6; i++)
        begin
            fp_cond = 6'h01 << i;
            fire(4, hit);
            `CHK("fp_mf", 8'h10, deliver_vector)
            fire(5, hit);
            `CHK("fp_xf", 8'h13, deliver_vector)
        end
    endtask

    // Long mode frame with and without a privilege change
    task automatic t_long();
        long_mode = 1;
        current_privilege_level = 2'h3;
        ss_in = 16'h2b;
        stack_pointer = 64'h8000;
        swi_vector = 8'h20;
        fire(2, hit);
        `CHK("l_code64", 1'b1, code64)
        `CHK("l_ssnull", 1'b1, ss_null_load)
        `CHK("l_newss", 16'h0, new_ss)
        `CHK("l_a0", 64'h7ff8, wa[0])
        `CHK("l_ss", 64'h2b, wd[0])
        `CHK("l_sp", 64'h8000, wd[1])
        `CHK("l_nsp", 64'h7fd8, new_sp)
        current_privilege_level = 2'h0;
        fire(2, hit);
        `CHK("l_nw", 5, wa.size())
        `CHK("l_nonull", 1'b0, ss_null_load)
        fire(6, hit);
        `CHK("l_ir_hit", 1'b1, resume)
        `CHK("l_ir_sp", ~64'h8018, res_sp)
        `CHK("l_ir_ss", 16'h7fdf, res_ss)
        system_management_interrupt = 1;
        fire(2, hit);
        `CHK("l_smi", 1'b0, code64)
        system_management_interrupt = 0;
        long_mode = 0;
    endtask

    // Task gate entry saves the context, task return restores it
    task automatic t_task();
        task_gate = 1;
        fire(2, hit);
        `CHK("tg_sw", 1'b1, task_switch)
        `CHK("tg_nw", 5, wa.size())
        `CHK("tg_a4", 64'h220, wa[4])
        `CHK("tg_ip", 64'habc, wd[0])
        fire(7, hit);
        `CHK("tr_hit", 1'b1, resume)
        `CHK("tr_ip", ~64'h200, res_ip)
        `CHK("tr_cs", 16'hfdf7, res_cs)
        task_gate = 0;
    endtask

    // ==================================================
    // Verdict and end of run
    task automatic end_sim();
        if (fail_count == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(negedge ref_clk);
        arst_n = 1;
        t_real();
        t_ovf();
        t_swi_bound();
        t_fp();
        t_long();
        t_task();
        end_sim();
    end
endmodule
`default_nettype wire
